//--- logic/wss_pkg.sv
// Constants, types and register map of the waveform sequence slot block.
// Assumes a 20 MHz clock and an AXI4-Lite master with 32-bit data.
package wss_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int SLOT_COUNT = 8;
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_CONTROL = 6'h0C;
	localparam logic [5:0] IDX_STATUS = 6'h0D;
	localparam logic [5:0] IDX_SLOT_FIRST = 6'h0F;
	localparam logic [5:0] IDX_SLOT_SECOND = 6'h10;
	localparam logic [5:0] IDX_SLOT_SEVEN = 6'h15;
	localparam logic [5:0] IDX_SLOT_EIGHT = 6'h16;
	localparam logic [7:0] SLOT_RESET = 8'h00;
	localparam int SLOT_DELAY_BIT = 7;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DELAY_BIT = 1;
	localparam int STAT_PTR_LSB = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLOCK_HZ = 20_000_000;
	localparam int DELAY_UNIT_MS = 10;
	localparam int DELAY_UNIT_CYCLES = CLOCK_HZ / 1000 * DELAY_UNIT_MS;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FETCH = 2'h1,
		ST_PLAY = 2'h3,
		ST_DELAY = 2'h2
	} wss_state_type;
endpackage : wss_pkg

//--- logic/wss_tmr_if.sv
// Link between the sequencer and its delay timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface wss_tmr_if;
	logic start;
	logic [6:0] units;
	logic done;
	modport tmr (input start, input units, output done);
	modport seq (output start, output units, input done);
endinterface : wss_tmr_if

//--- logic/wss_delay_timer.sv
// Idle timer that counts a number of 10 ms units.
// Assumes start is a one-cycle pulse given only while the timer is free.
`timescale 1ns/1ps
module wss_delay_timer #(
	parameter int TICK_CYCLES = wss_pkg::DELAY_UNIT_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	wss_tmr_if.tmr tmr_port
);
	import wss_pkg::*;
	localparam int CW = $clog2(TICK_CYCLES + 1);
	localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

	generate
		if (TICK_CYCLES < 1) begin : g_bad_tick
			$error("TICK_CYCLES must be at least one");
		end
	endgenerate

	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic [6:0] units_ff, nxt_units;

	always_comb begin
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_cnt = cnt_ff;
		nxt_units = units_ff;
		if (!busy_ff) begin
			if (tmr_port.start) begin
				nxt_busy = 1'b1;
				nxt_cnt = '0;
				nxt_units = tmr_port.units;
			end
		end else if (units_ff == 7'h00) begin
			nxt_busy = 1'b0;
			nxt_done = 1'b1;
		end else if (cnt_ff == TICK_LAST) begin
			nxt_cnt = '0;
			nxt_units = units_ff - 7'h01;
		end else begin
			nxt_cnt = cnt_ff + CW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= '0;
			units_ff <= 7'h00;
		end else begin
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			cnt_ff <= nxt_cnt;
			units_ff <= nxt_units;
		end
	end

	assign tmr_port.done = done_ff;

	////////////////////////////////////////////////////////////////////////////////
	// A unit is spent only when a full tick period has run out.
	a_unit_hold: assert property (@(posedge clock) disable iff (rst)
		busy_ff && units_ff != 7'h00 && cnt_ff != TICK_LAST |=> $stable(units_ff))
		else $error("delay unit spent before its tick period ended");
endmodule : wss_delay_timer

//--- logic/wss_sequencer.sv
// Eight-slot waveform sequence table with its playback walker and AXI4-Lite slave.
// Assumes a playback engine that pulses waveform_done when a started waveform ends.
`timescale 1ns/1ps
module wss_sequencer #(
	parameter int TICK_CYCLES = wss_pkg::DELAY_UNIT_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [wss_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [wss_pkg::AXI_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [wss_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [wss_pkg::AXI_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic play_start,
	output logic [6:0] play_index,
	input wire logic waveform_done,
	output logic seq_busy,
	output logic delay_active
);
	import wss_pkg::*;

	function automatic logic reg_known(input logic [5:0] idx);
		return idx == IDX_CONTROL || idx == IDX_STATUS ||
			(idx >= IDX_SLOT_FIRST && idx <= IDX_SLOT_EIGHT);
	endfunction : reg_known

	function automatic logic is_slot(input logic [5:0] idx);
		return idx >= IDX_SLOT_FIRST && idx <= IDX_SLOT_EIGHT;
	endfunction : is_slot

	logic [7:0] slot_ff [SLOT_COUNT];
	logic [7:0] nxt_slot [SLOT_COUNT];
	logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
	logic [5:0] wr_idx_ff, nxt_wr_idx;
	logic [7:0] wr_data_ff, nxt_wr_data;
	logic wr_lane_ff, nxt_wr_lane;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic start_req;
	logic rvalid_ff, nxt_rvalid;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [AXI_DW-1:0] rdata_ff, nxt_rdata;
	wss_state_type state_ff, nxt_state;
	logic [2:0] ptr_ff, nxt_ptr;
	logic play_start_ff, nxt_play_start;
	logic [6:0] play_index_ff, nxt_play_index;
	logic [7:0] cur_slot;
	logic [6:0] cur_id;
	logic step_done;
	logic [5:0] rd_idx;

	wss_tmr_if tmr_bus();

	wss_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.clock(clock),
		.rst(rst),
		.tmr_port(tmr_bus)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are held until both are present.
	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready = !w_hold_ff && !bvalid_ff;

	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold = w_hold_ff;
		nxt_wr_idx = wr_idx_ff;
		nxt_wr_data = wr_data_ff;
		nxt_wr_lane = wr_lane_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_slot = slot_ff;
		start_req = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_hold = 1'b1;
			nxt_wr_idx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_hold = 1'b1;
			nxt_wr_data = s_axi_wdata[7:0];
			nxt_wr_lane = s_axi_wstrb[0];
		end
		if (aw_hold_ff && w_hold_ff) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = reg_known(wr_idx_ff) ? RESP_OKAY : RESP_SLVERR;
			if (wr_lane_ff && is_slot(wr_idx_ff)) begin
				nxt_slot[3'(wr_idx_ff - IDX_SLOT_FIRST)] = wr_data_ff;
			end
			if (wr_lane_ff && wr_idx_ff == IDX_CONTROL) begin
				start_req = wr_data_ff[CTRL_START_BIT];
			end
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			wr_idx_ff <= 6'h00;
			wr_data_ff <= 8'h00;
			wr_lane_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			for (int i = 0; i < SLOT_COUNT; i++) begin
				slot_ff[i] <= SLOT_RESET;
			end
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			wr_idx_ff <= nxt_wr_idx;
			wr_data_ff <= nxt_wr_data;
			wr_lane_ff <= nxt_wr_lane;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			slot_ff <= nxt_slot;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Read channel: one read at a time, answered the cycle after the address.
	assign s_axi_arready = !rvalid_ff;
	assign rd_idx = s_axi_araddr[7:2];

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = reg_known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			nxt_rdata = '0;
			if (is_slot(rd_idx)) begin
				nxt_rdata[7:0] = slot_ff[3'(rd_idx - IDX_SLOT_FIRST)];
			end else if (rd_idx == IDX_STATUS) begin
				nxt_rdata[STAT_BUSY_BIT] = state_ff != ST_IDLE;
				nxt_rdata[STAT_DELAY_BIT] = state_ff == ST_DELAY;
				nxt_rdata[STAT_PTR_LSB +: 3] = ptr_ff;
			end
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= '0;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Sequence walker: fetch a slot, then play it or idle on it, then advance.
	assign cur_slot = slot_ff[ptr_ff];
	assign cur_id = cur_slot[6:0];
	assign step_done = (state_ff == ST_PLAY && waveform_done) ||
		(state_ff == ST_DELAY && tmr_bus.done);
	assign tmr_bus.units = cur_id;
	assign tmr_bus.start = state_ff == ST_FETCH && cur_id != 7'h00 &&
		cur_slot[SLOT_DELAY_BIT];

	always_comb begin
		nxt_state = state_ff;
		nxt_ptr = ptr_ff;
		nxt_play_start = 1'b0;
		nxt_play_index = play_index_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (start_req) begin
					nxt_state = ST_FETCH;
					nxt_ptr = 3'h0;
				end
			end
			ST_FETCH: begin
				if (cur_id == 7'h00) begin
					nxt_state = ST_IDLE;
				end else if (cur_slot[SLOT_DELAY_BIT]) begin
					nxt_state = ST_DELAY;
				end else begin
					nxt_state = ST_PLAY;
					nxt_play_start = 1'b1;
					nxt_play_index = cur_id;
				end
			end
			ST_PLAY, ST_DELAY: begin
				if (step_done) begin
					if (ptr_ff == 3'h7) begin
						nxt_state = ST_IDLE;
					end else begin
						nxt_state = ST_FETCH;
						nxt_ptr = ptr_ff + 3'h1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			ptr_ff <= 3'h0;
			play_start_ff <= 1'b0;
			play_index_ff <= 7'h00;
		end else begin
			state_ff <= nxt_state;
			ptr_ff <= nxt_ptr;
			play_start_ff <= nxt_play_start;
			play_index_ff <= nxt_play_index;
		end
	end

	assign play_start = play_start_ff;
	assign play_index = play_index_ff;
	assign seq_busy = state_ff != ST_IDLE;
	assign delay_active = state_ff == ST_DELAY;

	////////////////////////////////////////////////////////////////////////////////
	sequence s_enter_delay;
		state_ff == ST_FETCH && cur_id != 7'h00 && cur_slot[SLOT_DELAY_BIT];
	endsequence
	sequence s_enter_play;
		state_ff == ST_FETCH && cur_id != 7'h00 && !cur_slot[SLOT_DELAY_BIT];
	endsequence

	a_delay_silent: assert property (@(posedge clock) disable iff (rst)
		s_enter_delay |=> (state_ff == ST_DELAY && !play_start) [*2])
		else $error("waveform started during an idle slot");
	a_index_plays: assert property (@(posedge clock) disable iff (rst)
		s_enter_play |=> play_start && play_index == $past(cur_id) ##1 !play_start)
		else $error("played index differs from slot value");
	a_start_first: assert property (@(posedge clock) disable iff (rst)
		state_ff == ST_IDLE && start_req |=> state_ff == ST_FETCH && ptr_ff == 3'h0)
		else $error("start did not begin at the first slot");
	a_slot_advance: assert property (@(posedge clock) disable iff (rst)
		step_done && ptr_ff != 3'h7 |=> state_ff == ST_FETCH && ptr_ff == $past(ptr_ff) + 3'h1)
		else $error("walker did not move to the next slot");
	a_seq_end: assert property (@(posedge clock) disable iff (rst)
		(state_ff == ST_FETCH && cur_id == 7'h00) or (step_done && ptr_ff == 3'h7)
		|=> state_ff == ST_IDLE)
		else $error("sequence did not end at zero or after the eighth slot");
	a_slots_reset: assert property (@(posedge clock)
		$past(rst) |-> slot_ff[6] == SLOT_RESET && slot_ff[7] == SLOT_RESET)
		else $error("slots seven and eight not zero after reset");
endmodule : wss_sequencer

//--- test/wss_sequencer_tb.sv
// Self-checking bench for the waveform sequence slot block over AXI4-Lite.
// Assumes the sequencer top with a short delay tick; the bench acts as playback engine.
`timescale 1ns/1ps
module wss_sequencer_tb;
	import wss_pkg::*;
	localparam int TK = 4;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic wdone = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, play_start, seq_busy, delay_active;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [6:0] play_index;
	logic [7:0] prog [8];
	logic [6:0] plays [$];
	int waits [$];
	int error_cnt = 0, checks_done = 0, wcnt = 0, dcnt = 0, overlap = 0;
	wss_sequencer #(.TICK_CYCLES(TK)) u_dut (
		.clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.play_start(play_start), .play_index(play_index), .waveform_done(wdone),
		.seq_busy(seq_busy), .delay_active(delay_active));
	initial begin
		forever #25 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	// The bench answers each started waveform three cycles later and times idle gaps.
	always @(posedge clock) begin
		if (play_start === 1'b1) begin
			plays.push_back(play_index);
			wcnt <= 3;
			if (delay_active === 1'b1) overlap++;
		end else if (wcnt != 0) begin
			wcnt <= wcnt - 1;
		end
		wdone <= (wcnt == 1);
		if (delay_active === 1'b1) begin
			dcnt++;
		end else if (dcnt != 0) begin
			waits.push_back(dcnt);
			dcnt = 0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] ra(input logic [5:0] i);
		return {i, 2'b00};
	endfunction : ra
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val
	task automatic chk_rsp(input string what, input logic [1:0] exp, input logic [1:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_rsp
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 50) chk_val("write_answer", 1, 0);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 50) chk_val("read_answer", 1, 0);
	endtask : axi_rd
	////////////////////////////////////////////////////////////////////////////////
	// Loads the table, starts it and compares plays and gaps with a walk of the table.
	task automatic run_seq(input string name);
		int i, n;
		logic [1:0] r;
		logic [31:0] d;
		logic [6:0] ep [$];
		int ew [$];
		for (i = 0; i < 8; i++) axi_wr(ra(6'(IDX_SLOT_FIRST + i)), {24'h00_0000, prog[i]}, r);
		for (i = 0; i < 8 && prog[i][6:0] != 7'h00; i++) begin
			if (prog[i][7]) ew.push_back(int'(prog[i][6:0]));
			else ep.push_back(prog[i][6:0]);
		end
		plays.delete();
		waits.delete();
		axi_wr(ra(IDX_CONTROL), 32'h0000_0001, r);
		for (n = 0; n < 20 && seq_busy !== 1'b1; n++) @(posedge clock);
		chk_val("busy_start", 1, seq_busy);
		// The first slot is still running here, so status shows slot 0 and its kind.
		axi_rd(ra(IDX_STATUS), d, r);
		chk_rsp("status_rresp", RESP_OKAY, r);
		chk_val("status_run", (32'h1 << STAT_BUSY_BIT) | (32'(prog[0][7]) << STAT_DELAY_BIT), d);
		for (n = 0; n < 3000 && seq_busy === 1'b1; n++) @(posedge clock);
		repeat (2) @(posedge clock);
		chk_val("busy_end", 0, seq_busy);
		chk_val("play_count", ep.size(), plays.size());
		chk_val("wait_count", ew.size(), waits.size());
		for (i = 0; i < ep.size() && i < plays.size(); i++)
			chk_val("play_index", ep[i], plays[i]);
		for (i = 0; i < ew.size() && i < waits.size(); i++)
			chk_val("wait_len", 1, waits[i] >= ew[i] * TK && waits[i] <= ew[i] * TK + 3);
		chk_val("play_in_gap", 0, overlap);
		$display("test %s done", name);
	endtask : run_seq
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#2_000_000;
		error_cnt++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		axi_rd(ra(IDX_SLOT_SEVEN), d, r);
		chk_val("slot7_reset", 32'h0000_0000, d);
		axi_rd(ra(IDX_SLOT_EIGHT), d, r);
		chk_val("slot8_reset", 32'h0000_0000, d);
		axi_wr(ra(IDX_SLOT_SEVEN), 32'h0000_00A5, r);
		chk_rsp("slot7_wresp", RESP_OKAY, r);
		axi_wr(ra(IDX_SLOT_EIGHT), 32'h0000_005A, r);
		axi_rd(ra(IDX_SLOT_SEVEN), d, r);
		chk_val("slot7_rw", 32'h0000_00A5, d);
		axi_rd(ra(IDX_SLOT_EIGHT), d, r);
		chk_val("slot8_rw", 32'h0000_005A, d);
		chk_rsp("slot8_rresp", RESP_OKAY, r);
		axi_wr(8'h38, 32'h0000_0011, r);
		chk_rsp("unmapped_wr", RESP_SLVERR, r);
		axi_rd(8'h38, d, r);
		chk_rsp("unmapped_rd", RESP_SLVERR, r);
		$display("test registers done");
		prog = '{8'h05, 8'h82, 8'h13, 8'h24, 8'h35, 8'h46, 8'h83, 8'h7F};
		run_seq("slot7_gap");
		prog[6] = 8'h22;
		prog[7] = 8'h81;
		run_seq("slot8_gap");
		prog[2] = 8'h80;
		run_seq("zero_stop");
		end_of_test();
	end
endmodule : wss_sequencer_tb
